// file: clk_pll_ctrl.sv
// Clock generator control: boot source, PLL lock gating, power modes
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module clk_pll_ctrl #(
    parameter int NPERIPH = 12
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] boot_clock_mode_pins,
    input wire logic crystal_pin,
    input wire logic external_clock_pin,
    input wire logic pll_clk,
    input wire logic irq_any,
    input wire logic ext_irq,
    input wire clk_pll_pkg::apb_req_t apb_req,
    output clk_pll_pkg::apb_rsp_t apb_rsp,
    output logic mclk,
    output logic pll_en,
    output logic [8:0] pll_mult,
    output logic [6:0] pll_prediv,
    output logic [1:0] pll_post,
    output logic xtal_drv_en,
    output logic test_mode,
    output logic timer_external_tick,
    output logic cpu_clk_en,
    output logic lcd_clk_en,
    output logic [NPERIPH-1:0] periph_clk_en
);
    import clk_pll_pkg::*;

    function automatic logic src_level(input src_t s, input logic r,
                                       input logic sl, input logic p);
        unique case (s)
            SRC_OFF: src_level = 1'b0;
            SRC_REF: src_level = r;
            SRC_SLOW: src_level = sl;
            SRC_PLL: src_level = p;
        endcase
    endfunction : src_level

    // Reset release and input synchronisers
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [6:0] in_s1_reg;
    logic [6:0] in_s2_reg;
    logic [2:0] clk_d3_reg;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_reg <= 2'h0;
            in_s1_reg <= 7'h00;
            in_s2_reg <= 7'h00;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
            in_s1_reg <= {boot_clock_mode_pins, ext_irq, irq_any, pll_clk,
                          external_clock_pin, crystal_pin};
            in_s2_reg <= in_s1_reg;
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Boot mode latched once at reset release
    logic boot_done_reg;
    logic [1:0] boot_mode_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_done_reg <= 1'b0;
            boot_mode_reg <= BOOT_XTAL;
        end
        else if (!boot_done_reg)
        begin
            boot_done_reg <= 1'b1;
            boot_mode_reg <= in_s2_reg[6:5];
        end
    end

    wire use_ext = (boot_mode_reg == BOOT_EXT);
    wire ref_lvl = use_ext ? in_s2_reg[1] : in_s2_reg[0];
    wire ref_prev = use_ext ? clk_d3_reg[1] : clk_d3_reg[0];
    wire ref_rise = ref_lvl && !ref_prev;
    wire pll_lvl = in_s2_reg[2];
    wire irq_s = in_s2_reg[3];
    wire eirq_s = in_s2_reg[4];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            clk_d3_reg <= 3'h0;
        else
            clk_d3_reg <= in_s2_reg[2:0];
    end

    // APB decode
    wire setup = apb_req.psel && !apb_req.penable;
    wire acc = apb_req.psel && apb_req.penable;
    wire [7:0] adr = apb_req.paddr;
    wire hit_cfg = (adr == OFS_PLL_CFG);
    wire hit_lock = (adr == OFS_LOCK_CNT);
    wire hit_con = (adr == OFS_CLK_CON);
    wire hit_slow = (adr == OFS_CLK_SLOW);
    wire hit_stat = (adr == OFS_STATUS);
    wire mapped = hit_cfg || hit_lock || hit_con || hit_slow || hit_stat;
    wire wr = acc && apb_req.pwrite && mapped;
    wire [31:0] wd = apb_req.pwdata;
    wire wr_cfg = wr && hit_cfg;
    wire wr_con = wr && hit_con;
    wire wr_slow = wr && hit_slow;

    // Software registers
    pll_cfg_t cfg_reg;
    logic [LOCK_W-1:0] lock_cnt_reg;
    logic [NPERIPH-1:0] per_en_reg;
    logic lcd_en_reg;
    logic [SLOW_W-1:0] slow_divider_value_reg;
    logic slow_en_reg;
    logic pll_off_reg;
    logic pll_sel_reg;
    pm_state_t pm_reg;
    pm_state_t pm_next;

    wire wake_lcd = (pm_reg == PM_LCD_IDLE) && eirq_s;
    wire wake_stop = (pm_reg == PM_STOP) && eirq_s;
    wire pll_on_req = wr_slow && pll_off_reg && !wd[PLL_OFF_BIT];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reg <= '{fb: FB_RST, pre: PRE_RST, post: POST_RST};
            lock_cnt_reg <= LOCK_RST;
            per_en_reg <= '1;
            lcd_en_reg <= 1'b1;
            slow_divider_value_reg <= '0;
            slow_en_reg <= 1'b0;
            pll_off_reg <= 1'b0;
            pll_sel_reg <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
            begin
                cfg_reg.fb <= wd[FB_LSB +: FB_W];
                cfg_reg.pre <= wd[PRE_LSB +: PRE_W];
                cfg_reg.post <= wd[POST_LSB +: POST_W];
                pll_sel_reg <= 1'b1;
            end
            if (wr && hit_lock)
                lock_cnt_reg <= wd[LOCK_W-1:0];
            if (wr_con)
            begin
                per_en_reg <= wd[NPERIPH-1:0];
                lcd_en_reg <= wd[LCD_EN_BIT];
            end
            if (wake_lcd)
                slow_en_reg <= 1'b1;
            else if (wr_slow)
                slow_en_reg <= wd[SLOW_EN_BIT];
            if (wr_slow)
            begin
                slow_divider_value_reg <= wd[SLOW_W-1:0];
                pll_off_reg <= wd[PLL_OFF_BIT];
            end
        end
    end

    // Lock sequence: reset, config write, wake, PLL turned back on
    logic [LOCK_W-1:0] lock_ctr_reg;
    logic lock_gate_reg;
    wire lock_start = !boot_done_reg || wr_cfg || wake_stop || wake_lcd
                      || pll_on_req;
    wire lock_busy = (lock_ctr_reg != '0);
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            lock_ctr_reg <= '0;
        else if (lock_start)
            lock_ctr_reg <= lock_cnt_reg;
        else if (lock_busy && ref_rise)
            lock_ctr_reg <= lock_ctr_reg - 1'b1;
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            lock_gate_reg <= 1'b0;
        else if (wr_cfg || wake_stop)
            lock_gate_reg <= 1'b1;
        else if (!lock_busy)
            lock_gate_reg <= 1'b0;
    end

    // Power mode machine
    logic [4:0] stop_ctr_reg;
    always_comb
    begin
        pm_next = pm_reg;
        unique case (pm_reg)
            PM_RUN:
            begin
                if (wr_con && wd[STOP_BIT])
                    pm_next = slow_en_reg ? PM_STOP : PM_STOP_ENTER;
                else if (wr_con && wd[LCD_IDLE_BIT] && slow_en_reg)
                    pm_next = PM_LCD_IDLE;
                else if (wr_con && wd[IDLE_BIT])
                    pm_next = PM_IDLE;
            end
            PM_IDLE:
                if (irq_s)
                    pm_next = PM_RUN;
            PM_STOP_ENTER:
                if (stop_ctr_reg == STOP_REF_CYCLES)
                    pm_next = PM_STOP;
            PM_STOP:
                if (eirq_s)
                    pm_next = PM_RUN;
            PM_LCD_IDLE:
                if (eirq_s)
                    pm_next = PM_RUN;
            default:
                pm_next = PM_RUN;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pm_reg <= PM_RUN;
            stop_ctr_reg <= '0;
        end
        else
        begin
            pm_reg <= pm_next;
            if (pm_reg != PM_STOP_ENTER)
                stop_ctr_reg <= '0;
            else if (ref_rise)
                stop_ctr_reg <= stop_ctr_reg + 1'b1;
        end
    end

    // Slow clock: toggles every slow value rising reference edges
    logic [SLOW_W-1:0] slow_ctr_reg;
    logic slow_clk_reg;
    wire slow_bypass = (slow_divider_value_reg == '0);
    wire slow_lvl = slow_bypass ? ref_lvl : slow_clk_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slow_ctr_reg <= '0;
            slow_clk_reg <= 1'b0;
        end
        else if (ref_rise && !slow_bypass)
        begin
            if (slow_ctr_reg + 1'b1 == slow_divider_value_reg)
            begin
                slow_ctr_reg <= '0;
                slow_clk_reg <= !slow_clk_reg;
            end
            else
                slow_ctr_reg <= slow_ctr_reg + 1'b1;
        end
    end

    // Source choice and glitch-free switching
    src_t want_src;
    src_t sel_reg;
    logic mclk_reg;
    always_comb
    begin
        if (pm_reg == PM_STOP)
            want_src = SRC_OFF;
        else if (pm_reg == PM_STOP_ENTER)
            want_src = SRC_REF;
        else if (slow_en_reg)
            want_src = SRC_SLOW;
        else if (lock_gate_reg)
            want_src = SRC_OFF;
        else if (pll_sel_reg && !pll_off_reg)
            want_src = SRC_PLL;
        else
            want_src = SRC_REF;
    end
    wire can_switch = !mclk_reg &&
                      !src_level(want_src, ref_lvl, slow_lvl, pll_lvl);
    wire src_t sel_next = can_switch ? want_src : sel_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= SRC_REF;
            mclk_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next;
            mclk_reg <= src_level(sel_next, ref_lvl, slow_lvl, pll_lvl);
        end
    end
    assign mclk = mclk_reg;

    // Timer tick from external clock pin
    logic tick_reg;
    wire tick_ok = (boot_mode_reg == BOOT_XTAL) && (sel_reg == SRC_PLL);
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_reg <= 1'b0;
        else
            tick_reg <= tick_ok && in_s2_reg[1];
    end
    assign timer_external_tick = tick_reg;

    // Clock enables and PLL controls
    wire run = (pm_reg == PM_RUN) || (pm_reg == PM_STOP_ENTER);
    assign cpu_clk_en = run;
    assign periph_clk_en = (run || pm_reg == PM_IDLE) ? per_en_reg : '0;
    assign lcd_clk_en = lcd_en_reg &&
                        (run || pm_reg == PM_IDLE || pm_reg == PM_LCD_IDLE);
    assign pll_en = (pm_reg != PM_STOP) && !pll_off_reg;
    assign pll_mult = {1'b0, cfg_reg.fb} + FB_OFFSET;
    assign pll_prediv = {1'b0, cfg_reg.pre} + PRE_OFFSET;
    assign pll_post = cfg_reg.post;
    assign xtal_drv_en = (boot_mode_reg == BOOT_XTAL);
    assign test_mode = boot_mode_reg[1];

    // APB read data
    logic [31:0] rdata_reg;
    wire [31:0] rd_cfg = {12'h000, cfg_reg.fb, 2'h0, cfg_reg.pre, 2'h0,
                          cfg_reg.post};
    wire [31:0] rd_con = {12'h000, lcd_en_reg, 3'h0,
                          {(16 - NPERIPH){1'b0}}, per_en_reg};
    wire [31:0] rd_slow = {26'h0000000, pll_off_reg, slow_en_reg,
                           slow_divider_value_reg};
    wire [31:0] rd_stat = {20'h00000, pll_sel_reg, lock_busy,
                           boot_mode_reg, 2'h0, pm_reg};
    wire [31:0] rd_mux = hit_cfg ? rd_cfg :
                         hit_lock ? {20'h00000, lock_cnt_reg} :
                         hit_con ? rd_con :
                         hit_slow ? rd_slow :
                         hit_stat ? rd_stat : 32'h00000000;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= '0;
        else if (setup)
            rdata_reg <= rd_mux;
    end
    assign apb_rsp.prdata = rdata_reg;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = acc && !mapped;

    // Checks
    property p_boot_hold;
        @(posedge core_clk) disable iff (!rst_n)
        boot_done_reg |=> $stable(boot_mode_reg);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot moved");

    property p_ref_before_cfg;
        @(posedge core_clk) disable iff (!rst_n)
        !pll_sel_reg |-> sel_reg != SRC_PLL;
    endproperty
    a_ref_before_cfg: assert property (p_ref_before_cfg) else $error("pll early");

    property p_cfg_gates;
        @(posedge core_clk) disable iff (!rst_n)
        wr_cfg && !slow_en_reg && pm_reg == PM_RUN && lock_cnt_reg != '0
        |=> lock_gate_reg && want_src == SRC_OFF;
    endproperty
    a_cfg_gates: assert property (p_cfg_gates) else $error("no gating");

    property p_lock_count;
        @(posedge core_clk) disable iff (!rst_n)
        lock_busy && !lock_start && ref_rise |=>
        lock_ctr_reg == $past(lock_ctr_reg) - 1'b1;
    endproperty
    a_lock_count: assert property (p_lock_count) else $error("lock count");

    property p_pll_after_lock;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(lock_gate_reg) && pll_sel_reg && !pll_off_reg &&
        !slow_en_reg && pm_reg == PM_RUN |-> want_src == SRC_PLL;
    endproperty
    a_pll_after_lock: assert property (p_pll_after_lock) else $error("no pll");

    property p_idle_wake;
        @(posedge core_clk) disable iff (!rst_n)
        pm_reg == PM_IDLE && irq_s |=> pm_reg == PM_RUN && cpu_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle stuck");

    property p_stop_frozen;
        @(posedge core_clk) disable iff (!rst_n)
        pm_reg == PM_STOP |-> !pll_en && !cpu_clk_en && !lcd_clk_en
        && periph_clk_en == '0;
    endproperty
    a_stop_frozen: assert property (p_stop_frozen) else $error("stop clk");

    property p_lcd_only;
        @(posedge core_clk) disable iff (!rst_n)
        pm_reg == PM_LCD_IDLE |-> !cpu_clk_en && periph_clk_en == '0;
    endproperty
    a_lcd_only: assert property (p_lcd_only) else $error("lcd idle clk");

    property p_no_glitch;
        @(posedge core_clk) disable iff (!rst_n)
        sel_reg != $past(sel_reg) |-> !$past(mclk_reg) && !mclk_reg;
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("switch glitch");

endmodule : clk_pll_ctrl

// file: clk_pll_pkg.sv
// Constants, field layouts and carrier types for the clock and PLL control
package clk_pll_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_PLL_CFG = 8'h00;
    localparam logic [7:0] OFS_LOCK_CNT = 8'h04;
    localparam logic [7:0] OFS_CLK_CON = 8'h08;
    localparam logic [7:0] OFS_CLK_SLOW = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // PLL configuration fields
    localparam int FB_LSB = 12;
    localparam int FB_W = 8;
    localparam int PRE_LSB = 4;
    localparam int PRE_W = 6;
    localparam int POST_LSB = 0;
    localparam int POST_W = 2;
    localparam logic [FB_W-1:0] FB_RST = 8'h38;
    localparam logic [PRE_W-1:0] PRE_RST = 6'h08;
    localparam logic [POST_W-1:0] POST_RST = 2'h1;
    localparam logic [8:0] FB_OFFSET = 9'h008;
    localparam logic [6:0] PRE_OFFSET = 7'h02;

    // Lock count
    localparam int LOCK_W = 12;
    localparam logic [LOCK_W-1:0] LOCK_RST = 12'hFFF;

    // Clock control fields
    localparam int IDLE_BIT = 16;
    localparam int STOP_BIT = 17;
    localparam int LCD_IDLE_BIT = 18;
    localparam int LCD_EN_BIT = 19;

    // Slow clock fields
    localparam int SLOW_W = 4;
    localparam int SLOW_EN_BIT = 4;
    localparam int PLL_OFF_BIT = 5;

    // Status fields
    localparam int ST_BOOT_LSB = 8;
    localparam int ST_LOCK_BIT = 10;
    localparam int ST_PSEL_BIT = 11;

    // Boot mode codes
    localparam logic [1:0] BOOT_XTAL = 2'h0;
    localparam logic [1:0] BOOT_EXT = 2'h1;

    // Reference cycles of reference clock on Fout before stop
    localparam logic [4:0] STOP_REF_CYCLES = 5'h10;

    typedef enum logic [5:0] {
        PM_RUN = 6'b000001,
        PM_IDLE = 6'b000010,
        PM_STOP_ENTER = 6'b000100,
        PM_STOP = 6'b001000,
        PM_LCD_IDLE = 6'b010000
    } pm_state_t;

    typedef enum logic [1:0] {
        SRC_OFF = 2'h0,
        SRC_REF = 2'h1,
        SRC_SLOW = 2'h2,
        SRC_PLL = 2'h3
    } src_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [FB_W-1:0] fb;
        logic [PRE_W-1:0] pre;
        logic [POST_W-1:0] post;
    } pll_cfg_t;

endpackage : clk_pll_pkg

// file: clk_source_model.sv
// Far-side clock sources: crystal, external clock and PLL output
`timescale 1ns/1ps
module clk_source_model (
    input wire logic core_clk,
    input wire logic pll_en,
    output logic crystal_pin,
    output logic external_clock_pin,
    output logic pll_clk
);
    int xc = 0;
    int ec = 0;
    logic pc = 1'b0;
    initial
    begin
        crystal_pin = 1'b0;
        external_clock_pin = 1'b0;
        pll_clk = 1'b0;
    end
    // Crystal and external clock run free at 25 and 16.7 MHz
    always @(posedge core_clk)
    begin
        xc <= (xc == 3) ? 0 : xc + 1;
        ec <= (ec == 5) ? 0 : ec + 1;
        pc <= ~pc;
        if (xc == 3)
            crystal_pin <= ~crystal_pin;
        if (ec == 5)
            external_clock_pin <= ~external_clock_pin;
        // PLL output 50 MHz, low while powered down
        if (!pll_en)
            pll_clk <= 1'b0;
        else if (pc)
            pll_clk <= ~pll_clk;
    end
endmodule : clk_source_model

// file: tb_top.sv
// Self-checking testbench for the clock and PLL control block
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); \
        end \
    end
module tb_top;
    import clk_pll_pkg::*;
    localparam int NP = 12;
    // Short lock so runs stay brief; real software needs a far longer one
    localparam int LOCK = 10;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] boot = 2'h0;
    logic irq_any = 1'b0;
    logic ext_irq = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic xtal, extc, pllc, mclk, pll_en, xdrv, tmode, tick, cpu_en, lcd_en;
    logic mclk_q, tick_q;
    logic [8:0] mult;
    logic [6:0] pre;
    logic [1:0] post;
    logic [NP-1:0] pen;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int comparisons = 0;

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    clk_source_model src (.core_clk(core_clk), .pll_en(pll_en),
        .crystal_pin(xtal), .external_clock_pin(extc), .pll_clk(pllc));

    clk_pll_ctrl #(.NPERIPH(NP)) DUT (.core_clk(core_clk), .arst_n(arst_n),
        .boot_clock_mode_pins(boot), .crystal_pin(xtal),
        .external_clock_pin(extc), .pll_clk(pllc), .irq_any(irq_any),
        .ext_irq(ext_irq), .apb_req(req), .apb_rsp(rsp), .mclk(mclk),
        .pll_en(pll_en), .pll_mult(mult), .pll_prediv(pre),
        .pll_post(post), .xtal_drv_en(xdrv), .test_mode(tmode),
        .timer_external_tick(tick), .cpu_clk_en(cpu_en),
        .lcd_clk_en(lcd_en), .periph_clk_en(pen));

    always @(posedge core_clk)
    begin
        mclk_q <= mclk;
        tick_q <= tick;
    end

    function automatic logic [31:0] cfg_word(input logic [7:0] f,
        input logic [5:0] p, input logic [1:0] s);
        return (32'(f) << FB_LSB) | (32'(p) << PRE_LSB) | 32'(s);
    endfunction : cfg_word

    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // One APB transfer, then one edge so its effect has landed
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 50)
        begin
            n_mismatch++;
            end_sim();
        end
        @(posedge core_clk);
    endtask : apb

    // Cycles between the second and third mclk rise seen
    task automatic period(output int p);
        int n;
        int s;
        n = 0;
        s = 0;
        p = 0;
        while (n < 600 && s < 3)
        begin
            @(posedge core_clk);
            n++;
            if (s == 2)
                p++;
            if (mclk === 1'b1 && mclk_q === 1'b0)
                s++;
        end
    endtask : period

    task automatic rises(input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc)
        begin
            @(posedge core_clk);
            cnt += (mclk === 1'b1 && mclk_q === 1'b0);
        end
    endtask : rises

    task automatic first_rise(output int n);
        n = 0;
        // Skip a pulse already under way when the task starts
        while (n < 400 && mclk !== 1'b0)
        begin
            @(posedge core_clk);
            n++;
        end
        while (n < 400 && !(mclk === 1'b1 && mclk_q === 1'b0))
        begin
            @(posedge core_clk);
            n++;
        end
    endtask : first_rise

    task automatic wait_cpu();
        int n;
        n = 0;
        while (n < 200 && cpu_en !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_cpu

    task automatic t_boot(input logic [1:0] code);
        int p;
        arst_n <= 1'b0;
        boot <= code;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        boot <= ~code;
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[9:8], code)
        `CHK(xdrv, code == BOOT_XTAL)
        `CHK(tmode, code[1])
        if (code == BOOT_EXT)
        begin
            period(p);
            `CHK(p, 12)
        end
    endtask : t_boot

    task automatic t_reset_state();
        int p;
        `CHK(pll_en, 1'b1)
        `CHK({mult, pre, post}, {9'h040, 7'h0A, 2'h1})
        apb(1'b0, OFS_PLL_CFG, 32'h0);
        `CHK(rd, cfg_word(FB_RST, PRE_RST, POST_RST))
        apb(1'b0, OFS_LOCK_CNT, 32'h0);
        `CHK(rd[LOCK_W-1:0], LOCK_RST)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[ST_PSEL_BIT], 1'b0)
        `CHK(rd[5:0], 6'h01)
        period(p);
        `CHK(p, 8)
        `CHK(tick, 1'b0)
    endtask : t_reset_state

    task automatic t_pll();
        int p;
        int n;
        apb(1'b1, OFS_LOCK_CNT, 32'(LOCK));
        apb(1'b1, OFS_PLL_CFG, cfg_word(8'h20, 6'h03, 2'h2));
        `CHK({mult, pre, post}, {9'h028, 7'h05, 2'h2})
        first_rise(n);
        `CHK(n inside {[LOCK * 8 - 8:LOCK * 8 + 24]}, 1'b1)
        period(p);
        `CHK(p, 4)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[ST_PSEL_BIT], 1'b1)
        n = 0;
        repeat (60)
        begin
            @(posedge core_clk);
            n += (tick !== tick_q);
        end
        `CHK(n > 4, 1'b1)
        apb(1'b1, OFS_LOCK_CNT, 32'(LOCK));
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[ST_LOCK_BIT], 1'b0)
        apb(1'b0, OFS_LOCK_CNT, 32'h0);
        `CHK(rd, 32'(LOCK))
    endtask : t_pll

    task automatic t_periph();
        apb(1'b1, OFS_CLK_CON, 32'h0008_0555);
        `CHK({lcd_en, pen}, {1'b1, 12'h555})
        apb(1'b1, OFS_CLK_CON, 32'h0000_0AAA);
        `CHK({lcd_en, pen}, {1'b0, 12'hAAA})
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, OFS_CLK_CON, 32'h0000_0FFF);
    endtask : t_periph

    task automatic t_idle();
        apb(1'b1, OFS_CLK_CON, 32'h0001_0FFF);
        `CHK({cpu_en, pen}, {1'b0, 12'hFFF})
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[5:0], 6'h02)
        irq_any <= 1'b1;
        wait_cpu();
        irq_any <= 1'b0;
        `CHK(cpu_en, 1'b1)
    endtask : t_idle

    task automatic t_slow();
        int p;
        apb(1'b1, OFS_CLK_SLOW, 32'h0000_0012);
        period(p);
        `CHK(p, 32)
        apb(1'b1, OFS_CLK_SLOW, 32'h0000_0010);
        period(p);
        `CHK(p, 8)
        apb(1'b1, OFS_CLK_SLOW, 32'h0);
        period(p);
        `CHK(p, 4)
    endtask : t_slow

    task automatic t_stop();
        int p;
        int n;
        apb(1'b1, OFS_CLK_CON, 32'h0002_0FFF);
        rises(300, n);
        `CHK(n inside {[16:18]}, 1'b1)
        `CHK({cpu_en, lcd_en, pen, pll_en}, 15'h0)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[5:0], 6'h08)
        ext_irq <= 1'b1;
        first_rise(n);
        `CHK(n inside {[LOCK * 8 - 8:LOCK * 8 + 40]}, 1'b1)
        wait_cpu();
        ext_irq <= 1'b0;
        `CHK({cpu_en, pll_en}, 2'h3)
        period(p);
        `CHK(p, 4)
    endtask : t_stop

    task automatic t_lcd();
        int p;
        apb(1'b1, OFS_CLK_SLOW, 32'h0000_0030);
        apb(1'b1, OFS_CLK_CON, 32'h000C_0FFF);
        `CHK({cpu_en, lcd_en, pen}, {2'h1, 12'h000})
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[5:0], 6'h10)
        ext_irq <= 1'b1;
        wait_cpu();
        ext_irq <= 1'b0;
        `CHK(cpu_en, 1'b1)
        apb(1'b0, OFS_CLK_SLOW, 32'h0);
        `CHK(rd[SLOW_EN_BIT], 1'b1)
        period(p);
        `CHK(p, 8)
        // Stop from slow mode is entered at once
        apb(1'b1, OFS_CLK_CON, 32'h0002_0FFF);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[5:0], 6'h08)
        ext_irq <= 1'b1;
        wait_cpu();
        ext_irq <= 1'b0;
        `CHK(cpu_en, 1'b1)
    endtask : t_lcd

    initial
    begin
        for (int c = 3; c >= 0; c--)
            t_boot(2'(c));
        t_reset_state();
        t_pll();
        t_periph();
        t_idle();
        t_slow();
        t_stop();
        t_lcd();
        end_sim();
    end

    // Whole run needs well under 20000 cycles
    initial
    begin
        #(50000 * 5);
        n_mismatch++;
        end_sim();
    end
endmodule : tb_top
